// file: logic/pdp_defines.vh
// Register offsets, field widths and reset values for the port direction and pullup slice
`ifndef PDP_DEFINES_VH
`define PDP_DEFINES_VH
`define PDP_PIN_COUNT 7
`define PDP_OFF_DATA 4'h0
`define PDP_OFF_PULLUP 4'h4
`define PDP_OFF_DIR 4'h8
`define PDP_RESET_DIR 7'h00
`define PDP_RESET_PULLUP 7'h00
`define PDP_RESET_LATCH 7'h00
`define PDP_RESP_OKAY 2'h0
`define PDP_RESP_SLVERR 2'h2
`endif

// file: logic/pdp_pin_sync.v
// Two-stage synchroniser for the sampled pin levels
`timescale 1ns/1ns
module pdp_pin_sync #(
  parameter WIDTH = 7
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // Asynchronous pin levels in, synchronised levels out
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] stage_one;

  // =====================================================
  // Synchroniser: first stage feeds only the second
  always @(posedge clock_i) begin
    if (rst_i) begin
      stage_one <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule // pdp_pin_sync

// file: logic/pdp_port.v
// Seven-pin parallel port slice with direction and pullup control over AXI4-Lite
// Notes on behaviour
// - With a direction bit clear the pin driver is off and a data read returns the sampled pin level.
// - With a direction bit set the pin driver is on and a data read returns the stored output latch bit.
// - For an input pin the internal pullup follows its pullup-enable bit.
// - For an output pin the pullup-enable bit is ignored and the pullup stays off.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
`include "pdp_defines.vh"

// =====================================================
// Bus timing seen from software
// Write: address and data are taken in either order, each when its valid meets its ready.
// Response: bvalid rises one edge after the later of the two, and the register and the pins
// change at that very edge, so a read issued after the response always sees the new value.
// Ready drops for at least two cycles after each handshake; a second write may be offered at once,
// it is simply held off until the slot is free and the previous response has been taken.
// Read: arready is high only while no answer is pending, rising one edge after the answer is taken; rvalid follows the address by one edge
// and stands, with its data, until rready is seen high.
// Unmapped words answer SLVERR; a write there changes nothing and a read returns zero.
// Only byte lane 0 carries bits; a write to a mapped word with that strobe clear answers OKAY and is a no-op.

// =====================================================
// Pin side
// The driver enable is the direction bit itself, so a pin turned to output drives at once.
// The pullup request is gated by the direction bit; an output never fights its own pullup.
// Pin levels are synchronised over two flops before anything reads them; a level change
// shows up in a data read two edges later than the pin, plus the read latency.
// Limitation: the data word returns the latch for outputs, so a shorted output pin cannot
// be detected through a read of the data word.

// =====================================================
// Reset
// Synchronous and active high; every register, the pins and all readies read zero.
// One edge in reset clears the synchroniser as well, since both of its stages take the reset.
module pdp_port #(
  parameter PINS = `PDP_PIN_COUNT
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_i,
  // AXI4-Lite write address and data
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address and data
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Port pins
  input wire [PINS-1:0] pin_i,
  output reg [PINS-1:0] pin_o,
  output reg [PINS-1:0] pin_oe_o,
  output reg [PINS-1:0] pin_pullup_o
);
  reg [PINS-1:0] pin_direction_bits;
  reg [PINS-1:0] pin_pullup_enable_bits;
  reg [PINS-1:0] output_latch_bit;
  reg [3:0] wr_addr;
  reg wr_addr_held;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg wr_data_held;
  wire [PINS-1:0] pin_sampled;
  wire [PINS-1:0] pin_data_value;
  wire wr_lane0;
  wire [PINS-1:0] next_latch;
  wire [PINS-1:0] next_pullup;
  reg [31:0] next_rdata;
  reg next_rerr;
  wire wr_go;
  wire [PINS-1:0] next_direction;

  // Decode of the mapped word addresses, shared by read and write paths
  function addr_mapped;
    input [3:0] addr;
    begin
      addr_mapped = (addr == `PDP_OFF_DATA) || (addr == `PDP_OFF_PULLUP) || (addr == `PDP_OFF_DIR);
    end
  endfunction

  // =====================================================
  // Pin input synchroniser
  pdp_pin_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pin_i),
    .sync_o(pin_sampled)
  );

  // =====================================================
  // Write channel capture; address and data may come in either order
  assign wr_go = wr_addr_held && wr_data_held && !s_axi_bvalid_o;

  always @(posedge clock_i) begin
    if (rst_i) begin
      wr_addr <= 4'h0;
      wr_addr_held <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      wr_data_held <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `PDP_RESP_OKAY;
    end else begin
      // Ready is offered only while the holding slot is free
      s_axi_awready_o <= !wr_addr_held && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !wr_data_held && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        wr_addr <= s_axi_awaddr_i;
        wr_addr_held <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wr_data <= s_axi_wdata_i;
        wr_strb <= s_axi_wstrb_i;
        wr_data_held <= 1'b1;
      end
      if (wr_go) begin
        wr_addr_held <= 1'b0;
        wr_data_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= addr_mapped(wr_addr) ? `PDP_RESP_OKAY : `PDP_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // =====================================================
  // Control registers; only byte lane 0 carries bits
  always @(posedge clock_i) begin
    if (rst_i) begin
      pin_direction_bits <= `PDP_RESET_DIR;
      pin_pullup_enable_bits <= `PDP_RESET_PULLUP;
      output_latch_bit <= `PDP_RESET_LATCH;
    end else if (wr_go && wr_strb[0]) begin
      case (wr_addr)
        `PDP_OFF_DATA: output_latch_bit <= wr_data[PINS-1:0];
        `PDP_OFF_PULLUP: pin_pullup_enable_bits <= wr_data[PINS-1:0];
        `PDP_OFF_DIR: pin_direction_bits <= wr_data[PINS-1:0];
        default: output_latch_bit <= output_latch_bit;
      endcase
    end
  end

  // =====================================================
  // Pin drive; computed from the next register values so pins track writes
  assign wr_lane0 = wr_go && wr_strb[0];
  assign next_direction = (wr_lane0 && wr_addr == `PDP_OFF_DIR) ? wr_data[PINS-1:0] : pin_direction_bits;
  assign next_latch = (wr_lane0 && wr_addr == `PDP_OFF_DATA) ? wr_data[PINS-1:0] : output_latch_bit;
  assign next_pullup = (wr_lane0 && wr_addr == `PDP_OFF_PULLUP) ? wr_data[PINS-1:0] : pin_pullup_enable_bits;

  always @(posedge clock_i) begin
    if (rst_i) begin
      pin_o <= {PINS{1'b0}};
      pin_oe_o <= {PINS{1'b0}};
      pin_pullup_o <= {PINS{1'b0}};
    end else begin
      pin_o <= next_latch;
      pin_oe_o <= next_direction;
      // Pullup only on inputs, whatever its enable bit says
      pin_pullup_o <= next_pullup & ~next_direction;
    end
  end

  // =====================================================
  // Read data mux; per pin, latch for outputs and pin level for inputs
  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : g_read
      assign pin_data_value[g] = pin_direction_bits[g] ? output_latch_bit[g] : pin_sampled[g];
    end
  endgenerate

  always @* begin
    next_rdata = 32'h00000000;
    next_rerr = 1'b0;
    case (s_axi_araddr_i)
      `PDP_OFF_DATA: next_rdata[PINS-1:0] = pin_data_value;
      `PDP_OFF_PULLUP: next_rdata[PINS-1:0] = pin_pullup_enable_bits;
      `PDP_OFF_DIR: next_rdata[PINS-1:0] = pin_direction_bits;
      default: next_rerr = !addr_mapped(s_axi_araddr_i);
    endcase
  end

  // =====================================================
  // Read channel; one read at a time, answer the cycle after the address
  always @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `PDP_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= next_rdata;
        s_axi_rresp_o <= next_rerr ? `PDP_RESP_SLVERR : `PDP_RESP_OKAY;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule // pdp_port

// file: tb/pdp_ext_model.sv
// Board circuitry seen by the port pins
`timescale 1ns/1ns
module pdp_ext_model (
  // Clock, device pin side and scenario control
  input wire clock_i,
  input wire [6:0] oe_i, out_i, pu_i, ext_en_i, ext_val_i,
  output logic [6:0] lvl_o
);
  logic [6:0] tog = 7'h55;
  // Floating pins wander, so a stale level is never trusted
  always @(posedge clock_i) tog <= ~tog;
  // Driver wins, then board source, then pullup
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | tog));
endmodule // pdp_ext_model

// file: tb/pdp_port_sva.sv
// Port slice checker
`timescale 1ns/1ns
module pdp_port_sva #(parameter PINS = 7) (
  // Watched ports
  input wire clock_i, rst_i, s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i,
  input wire s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  input wire [PINS-1:0] pin_o, pin_oe_o, pin_pullup_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_excl; (pin_oe_o & pin_pullup_o) == 0; endproperty
  a_excl: assert property (p_excl) else $error("pullup on an output pin");
  property p_rst; disable iff (1'b0) rst_i |=> pin_oe_o == 0 && pin_pullup_o == 0 && pin_o == 0; endproperty
  a_rst: assert property (p_rst) else $error("pins not cleared by reset");
  property p_oe; $changed(pin_oe_o) |-> $rose(s_axi_bvalid_o) || $past(rst_i); endproperty
  a_oe: assert property (p_oe) else $error("driver enable moved without a write");
  property p_pu; $changed(pin_pullup_o) |-> $rose(s_axi_bvalid_o) || $past(rst_i); endproperty
  a_pu: assert property (p_pu) else $error("pullup moved without a write");
  property p_ar; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rzero; s_axi_rvalid_o |-> s_axi_rdata_o[31:7] == 0; endproperty
  a_rzero: assert property (p_rzero) else $error("unused read bits set");
  c_wr: cover property ($rose(s_axi_bvalid_o));
  c_rd: cover property ($rose(s_axi_rvalid_o));
  c_pu: cover property (|pin_pullup_o);
endmodule // pdp_port_sva
bind pdp_port pdp_port_sva #(.PINS(PINS)) u_sva (.*);

// file: tb/tb.sv
// Self-checking bench for the port slice
`timescale 1ns/1ns
`include "pdp_defines.vh"
module tb;
  logic clock_i = 0, rst_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o;
  logic [3:0] s_axi_awaddr_i = 0, s_axi_wstrb_i = 4'hf, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd_d;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
  logic [6:0] pin_i, pin_o, pin_oe_o, pin_pullup_o, ext_en = 0, ext_val = 0, dir, pu, lat;
  int err_total = 0, compares = 0, seed = 32'h57a5;
  always #20 clock_i = ~clock_i;
  pdp_port dut (.*);
  pdp_ext_model u_ext (.clock_i(clock_i), .oe_i(pin_oe_o), .out_i(pin_o), .pu_i(pin_pullup_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin_i));
  // Compare and count
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bus master: address and data offered together
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i <= a; s_axi_wdata_i <= d; s_axi_awvalid_i <= 1; s_axi_wvalid_i <= 1; s_axi_bready_i <= 1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1);
    rsp = s_axi_bresp_o; s_axi_bready_i <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock_i);
    s_axi_araddr_i <= a; s_axi_arvalid_i <= 1; s_axi_rready_i <= 1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1);
    rd_d = s_axi_rdata_o; rsp = s_axi_rresp_o; s_axi_rready_i <= 0;
  endtask
  // Model check; floating unpulled inputs are masked out
  task check_all;
    logic [6:0] m, e;
    m = dir | ext_en | pu;
    e = (dir & lat) | (~dir & ext_en & ext_val) | (~dir & ~ext_en & pu);
    rd(`PDP_OFF_DATA); chk(rd_d & m, e & m);
    chk(pin_oe_o, dir);
    chk(pin_o, lat);
    chk(pin_pullup_o, pu & ~dir);
    rd(`PDP_OFF_PULLUP); chk(rd_d, pu);
    rd(`PDP_OFF_DIR); chk(rd_d, dir);
  endtask
  initial begin
    dir = 0; pu = 0; lat = 0;
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    check_all;
    repeat (24) begin
      dir = 7'($random(seed)); pu = 7'($random(seed)); lat = 7'($random(seed));
      ext_en <= 7'($random(seed)) & ~dir; ext_val <= 7'($random(seed));
      wr(`PDP_OFF_PULLUP, {25'h0, pu}); wr(`PDP_OFF_DIR, {25'h0, dir}); wr(`PDP_OFF_DATA, {25'h0, lat});
      chk(rsp, `PDP_RESP_OKAY);
      repeat (4) @(posedge clock_i);
      check_all;
    end
    // Unmapped place refuses both ways
    wr(4'hc, 32'h7f); chk(rsp, `PDP_RESP_SLVERR);
    // Lane 0 strobe clear: accepted, but the direction stays
    s_axi_wstrb_i <= 4'h0;
    wr(`PDP_OFF_DIR, ~{25'h0, dir}); chk(rsp, `PDP_RESP_OKAY);
    s_axi_wstrb_i <= 4'hf;
    rd(`PDP_OFF_DIR); chk(rd_d, dir);
    rd(4'hc); chk(rsp, `PDP_RESP_SLVERR); chk(rd_d, 32'h0);
    // Reset in mid-run clears the setup
    rst_i <= 1; repeat (2) @(posedge clock_i); rst_i <= 0;
    dir = 0; pu = 0; lat = 0;
    check_all;
    summarize;
  end
  // Watchdog well past the expected run
  initial begin
    #400000;
    err_total++;
    summarize;
  end
endmodule // tb
